/* File: logic/spcs_page_stack.sv */
/*
  Page context stack: current page select, second and third entries, auto paging control.
  Assumes the core pulses intEntry with the source page and intReturn one cycle each,
  and drives single-cycle register reads and writes; read data follows one cycle later.
*/
// Summary of operation
// R01: Auto paging on loads source page at entry
// R02: Auto paging off keeps current page at entry
// R03: Control bits 7:1 read zero; bit0 resets one
// R04: Three-entry stack: current, second, third
// R05: Only entry pushes, only return pops
// R06: Register access never pushes or pops stack
// R07: Second entry write sets page after return
// R08: Second entry read returns value, no effects
// R09: Push shifts down; pop shifts up, third kept
`timescale 1ns/100ps
`include "spcs_defines.svh"
module spcs_page_stack (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  output logic regRdValid,
  input wire logic intEntry,
  input wire spcs_pkg::spcs_page_t intSourcePage,
  input wire logic intReturn,
  output spcs_pkg::spcs_page_t currentPageSelect,
  output logic autoPageEnable
);
  import spcs_pkg::*;

  spcs_state_t state_q;
  spcs_state_t state_d;
  logic selControl;
  logic selSecond;
  logic selThird;
  logic selCurrent;

  spcs_reg_decode decode (
    .addr(regAddr),
    .curPage(state_q.current),
    .selControl(selControl),
    .selSecond(selSecond),
    .selThird(selThird),
    .selCurrent(selCurrent)
  );

  always_comb begin
    state_d = state_q;
    state_d.rdValid = regRead;
    state_d.rdData = 8'h00;
    if (regRead) begin
      if (selControl) begin
        state_d.rdData = {7'h00, state_q.autoPageEnable}; // [R03]
      end else if (selSecond) begin
        state_d.rdData = state_q.second; // [R08]
      end else if (selThird) begin
        state_d.rdData = state_q.third;
      end else if (selCurrent) begin
        state_d.rdData = state_q.current;
      end
    end
    // Single-entry writes touch only their own byte [R06]
    if (regWrite) begin
      if (selControl) begin
        state_d.autoPageEnable = regWrData[`SPCS_AUTO_PAGE_BIT]; // [R03]
      end
      if (selSecond) begin
        state_d.second = regWrData; // [R07]
      end
      if (selThird) begin
        state_d.third = regWrData;
      end
      if (selCurrent) begin
        state_d.current = regWrData;
      end
    end
    // Stack motion overrides a same-cycle register write; entry beats return
    if (intEntry) begin // [R05]
      state_d.third = state_q.second; // [R09] [R04]
      state_d.second = state_q.current; // [R09]
      if (state_q.autoPageEnable) begin
        state_d.current = intSourcePage; // [R01]
      end else begin
        state_d.current = state_q.current; // [R02]
      end
    end else if (intReturn) begin // [R05]
      state_d.current = state_q.second; // [R09] [R07]
      state_d.second = state_q.third; // [R09]
      state_d.third = state_q.third; // [R09]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q.autoPageEnable <= `SPCS_AUTO_PAGE_RESET; // [R03]
      state_q.current <= `SPCS_PAGE_RESET;
      state_q.second <= `SPCS_PAGE_RESET;
      state_q.third <= `SPCS_PAGE_RESET;
      state_q.rdData <= 8'h00;
      state_q.rdValid <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  assign regRdData = state_q.rdData;
  assign regRdValid = state_q.rdValid;
  assign currentPageSelect = state_q.current;
  assign autoPageEnable = state_q.autoPageEnable;
endmodule

/* File: logic/spcs_defines.svh */
/*
  Offsets, field positions, reset values and page numbers of the page context stack.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef SPCS_DEFINES_SVH
`define SPCS_DEFINES_SVH
`define SPCS_PAGE_CONTROL_ADDR 8'h84
`define SPCS_SECOND_ENTRY_ADDR 8'h85
`define SPCS_THIRD_ENTRY_ADDR 8'h86
`define SPCS_CURRENT_PAGE_ADDR 8'ha7
`define SPCS_PAGE_CONTROL_PAGE 8'h0f
`define SPCS_AUTO_PAGE_BIT 0
`define SPCS_AUTO_PAGE_RESET 1'b1
`define SPCS_PAGE_RESET 8'h00
`define SPCS_STACK_DEPTH 3
`endif

/* File: logic/spcs_pkg.sv */
/*
  Types shared by the page context stack modules.
  Assumes the defines header is on the include path.
*/
`include "spcs_defines.svh"
package spcs_pkg;
  typedef logic [7:0] spcs_page_t;
  typedef struct packed {
    logic autoPageEnable;
    spcs_page_t current;
    spcs_page_t second;
    spcs_page_t third;
    spcs_page_t rdData;
    logic rdValid;
  } spcs_state_t;
endpackage

/* File: logic/spcs_reg_decode.sv */
/*
  Address decoder for the page context registers on the special-function bus.
  Assumes a single-cycle bus with address, write and read strobes from the core.
*/
`timescale 1ns/100ps
`include "spcs_defines.svh"
module spcs_reg_decode (
  input wire logic [7:0] addr,
  input wire spcs_pkg::spcs_page_t curPage,
  output logic selControl,
  output logic selSecond,
  output logic selThird,
  output logic selCurrent
);
  import spcs_pkg::*;
  always_comb begin
    // Page control lives on one page only; the rest are on every page
    selControl = (addr == `SPCS_PAGE_CONTROL_ADDR) && (curPage == `SPCS_PAGE_CONTROL_PAGE);
    selSecond = (addr == `SPCS_SECOND_ENTRY_ADDR);
    selThird = (addr == `SPCS_THIRD_ENTRY_ADDR);
    selCurrent = (addr == `SPCS_CURRENT_PAGE_ADDR);
  end
endmodule

/* File: sim/spcs_checker.sv */
/* Page stack port assertions. Assumes bind onto spcs_page_stack. */
`timescale 1ns/100ps
module spcs_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic regRdValid,
  input wire logic intEntry,
  input wire logic intReturn,
  input wire logic autoPageEnable,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  input wire logic [7:0] intSourcePage,
  input wire logic [7:0] currentPageSelect
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_auto_load: assert property (intEntry && autoPageEnable |=>
    currentPageSelect == $past(intSourcePage)) else $error("no auto load");
  a_auto_off: assert property (intEntry && !autoPageEnable |=>
    $stable(currentPageSelect)) else $error("page moved");
  a_ctl_bits: assert property (regRdValid && $past(regAddr) == 8'h84 |->
    regRdData[7:1] == 7'h00) else $error("ctl bits");
  a_en_reset: assert property ($fell(rst) |-> autoPageEnable) else $error("en reset");
  a_rd_pulse: assert property (regRead |=> regRdValid) else $error("no rd valid");
  a_rd_cause: assert property (regRdValid |-> $past(regRead)) else $error("rd valid");
  a_rd_idle: assert property (!regRdValid |-> regRdData == 8'h00) else $error("rd idle");
  a_no_move: assert property (!intEntry && !intReturn && !(regWrite && regAddr == 8'ha7)
    |=> $stable(currentPageSelect)) else $error("stack moved");
endmodule
bind spcs_page_stack spcs_checker u_spcs_checker (.*);

/* File: sim/spcs_core_model.sv */
/* Core interrupt entry and return model. Assumes bench calls irq. */
`timescale 1ns/100ps
module spcs_core_model (
  input wire logic clk,
  output logic intEntry,
  output logic intReturn,
  output logic [7:0] intSourcePage
);
  initial {intEntry, intReturn, intSourcePage} = 10'h000;
  // Entry when e is 1, else return; page line inverted when idle
  task automatic irq(input logic e, input logic [7:0] p);
    @(posedge clk);
    {intEntry, intReturn, intSourcePage} <= {e, !e, p};
    @(posedge clk);
    {intEntry, intReturn, intSourcePage} <= {2'b00, ~p};
    #1;
  endtask
endmodule

/* File: sim/testbench.sv */
/* Page stack bench. Assumes design, checker and core model compiled first. */
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0, rst = 1'b1, regWrite = 1'b0, regRead = 1'b0;
  logic intEntry, intReturn, regRdValid, autoPageEnable;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, intSourcePage, currentPageSelect;
  int n_mismatch = 0, cmp_count = 0;
  always #5 clk = ~clk;
  spcs_page_stack u_spcs_page_stack (.*);
  spcs_core_model u_spcs_core_model (.clk, .intEntry, .intReturn, .intSourcePage);
  task automatic chk(input logic [7:0] s, e);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t saw %h want %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    {regAddr, regWrData, regWrite} <= {a, d, 1'b1};
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(posedge clk);
    {regAddr, regRead} <= {a, 1'b1};
    @(posedge clk);
    regRead <= 1'b0;
    #1 chk({7'h00, regRdValid}, 8'h01);
    chk(regRdData, e);
  endtask
  task automatic tally_and_finish;
    if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #20000;
    n_mismatch++;
    tally_and_finish;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(8'h85, 8'h00);
    chk({7'h00, autoPageEnable}, 8'h01);
    wr(8'ha7, 8'h0f);
    rd(8'h84, 8'h01);
    wr(8'h84, 8'hfe);
    rd(8'h84, 8'h00);
    chk({7'h00, autoPageEnable}, 8'h00);
    wr(8'h85, 8'h5a);
    chk(currentPageSelect, 8'h0f);
    u_spcs_core_model.irq(1'b1, 8'h33);
    chk(currentPageSelect, 8'h0f);
    rd(8'h85, 8'h0f);
    rd(8'h86, 8'h5a);
    wr(8'h85, 8'h21);
    u_spcs_core_model.irq(1'b0, 8'h00);
    chk(currentPageSelect, 8'h21);
    rd(8'h85, 8'h5a);
    rd(8'h86, 8'h5a);
    rd(8'ha7, 8'h21);
    // Control register is off its page here, so this write is refused
    wr(8'h84, 8'h01);
    chk({7'h00, autoPageEnable}, 8'h00);
    wr(8'ha7, 8'h0f);
    wr(8'h84, 8'h01);
    u_spcs_core_model.irq(1'b1, 8'h33);
    chk(currentPageSelect, 8'h33);
    rd(8'h85, 8'h0f);
    wr(8'h86, 8'h77);
    chk(currentPageSelect, 8'h33);
    rd(8'h85, 8'h0f);
    u_spcs_core_model.irq(1'b0, 8'h00);
    chk(currentPageSelect, 8'h0f);
    rd(8'h85, 8'h77);
    rd(8'h86, 8'h77);
    tally_and_finish;
  end
endmodule
